// File: logic/sqmf_cfg.svh
/*
 * constants of the S/Q multiframe channel: register offsets, field positions,
 * reset values and frame timing.
 * assumes a 200 MHz i_clock and a 4 kHz line frame.
 */
//
// Contract
// [R01] - network side sends 20-frame pattern: aux bit in 1,6,11,16; marker in 1.
// [R02] - aux-position upstream bits of frames 1,6,11,16 stored as four Q bits.
// [R03] - any stored Q bit changing sets the Q/S change interrupt status bit.
// [R04] - four transmit bits go out as S bits of frames 1,6,11,16.
// [R05] - S bit zero elsewhere; upstream Q position expected zero elsewhere.
// [R06] - enable bit in control register; cleared means no multiframe on line.
// [R07] - frame trigger may start each frame; outside party drives it at 4 kHz.
// [R08] - trigger held low: frames start from internal frame timing.
// [R09] - multiframe sync input acts on counter only while generation enabled.
// [R10] - sync sampled at trigger fall or frame start, whichever first.
// [R11] - sync sampled high forces frame 1 and marker one; held high stays reset.
// [R12] - sync low again: counter runs 20 frames and wraps by itself.
// [R13] - sync low for one frame: counter reaches frame 2, marker zero.
// [R14] - terminal mode drives received marker, muxed with echo bits, on sync pin.
// [R15] - outside logic should sample the marker at frame sync clock fall.
`ifndef SQMF_CFG_SVH
`define SQMF_CFG_SVH

// ****************************************************************
// timing
// ****************************************************************
`define SQMF_CLOCK_HZ       200000000
`define SQMF_FRAME_RATE_HZ  4000
`define SQMF_FRAME_CYCLES   (`SQMF_CLOCK_HZ / `SQMF_FRAME_RATE_HZ)
`define SQMF_FRAME_CNT_W    17
`define SQMF_MF_FIRST       5'h01
`define SQMF_MF_LAST        5'h14

// ****************************************************************
// register offsets
// ****************************************************************
`define SQMF_OFS_INT_STATUS 8'h00
`define SQMF_OFS_INT_MASK   8'h04
`define SQMF_OFS_CTRL_TWO   8'h08
`define SQMF_OFS_Q_RECEIVE  8'h0C
`define SQMF_OFS_S_TRANSMIT 8'h10

// ****************************************************************
// fields and reset values
// ****************************************************************
`define SQMF_INT_QSC_BIT    0
`define SQMF_CTRL_EN_BIT    0
`define SQMF_CTRL_TERM_BIT  1
`define SQMF_CTRL_EXT_BIT   2
`define SQMF_CTRL_FRM_LSB   8
`define SQMF_CTRL_EN_RESET  1'b1
`define SQMF_MASK_RESET     1'b0

`endif

// File: logic/sqmf_pkg.sv
/*
 * types of the S/Q multiframe channel.
 * assumes sqmf_cfg.svh for all numeric constants.
 */
package sqmf_pkg;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef struct packed {
        logic fa;
        logic m;
        logic s;
    } sqmf_tx_bits_t;

    typedef struct packed {
        logic       hit;
        logic [1:0] idx;
    } sqmf_slot_t;

    typedef enum logic {
        TRIG_INTERNAL = 1'b0,
        TRIG_EXTERNAL = 1'b1
    } sqmf_trig_src_t;

endpackage

// File: logic/sqmf_frame_timer.sv
/*
 * line frame timer: frame start pulse from the internal count or the
 * external 4 kHz trigger, and the sync sample pulse.
 * assumes i_trigger synchronous to i_clock.
 */
`include "sqmf_cfg.svh"

module sqmf_frame_timer
    import sqmf_pkg::*;
#(
    parameter int unsigned FRAME_CYCLES = `SQMF_FRAME_CYCLES
) (
    input  wire logic i_clock,
    input  wire logic i_nrst,
    input  wire logic i_trigger,
    output logic      o_frame_start,
    output logic      o_sample,
    output logic      o_ext_mode
);

    localparam logic [`SQMF_FRAME_CNT_W-1:0] LAST = `SQMF_FRAME_CNT_W'(FRAME_CYCLES - 1);
    localparam logic [`SQMF_FRAME_CNT_W-1:0] LOST = `SQMF_FRAME_CNT_W'(2 * FRAME_CYCLES);

    sqmf_trig_src_t                 src_ff;
    logic [`SQMF_FRAME_CNT_W-1:0]   cnt_ff;
    logic                           trig_ff;
    logic                           sampled_ff;
    logic                           rise;
    logic                           fall;
    logic                           lost;

    assign rise = i_trigger & ~trig_ff;
    assign fall = ~i_trigger & trig_ff;
    assign lost = (src_ff == TRIG_EXTERNAL) && (cnt_ff == LOST);

    // ****************************************************************
    // frame start
    // ****************************************************************
    always_comb begin
        unique case (src_ff)
            TRIG_INTERNAL: o_frame_start = rise | (cnt_ff == LAST); // [R08]
            TRIG_EXTERNAL: o_frame_start = rise;                    // [R07]
        endcase
    end

    assign o_sample   = ((src_ff == TRIG_EXTERNAL) & fall) | (o_frame_start & ~sampled_ff); // [R10]
    assign o_ext_mode = (src_ff == TRIG_EXTERNAL);

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            trig_ff <= 1'b0;
        end else begin
            trig_ff <= i_trigger;
        end
    end

    // trigger absent for two frames: fall back to internal timing
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            src_ff <= TRIG_INTERNAL;
        end else if (rise) begin
            src_ff <= TRIG_EXTERNAL;                                // [R07]
        end else if (lost) begin
            src_ff <= TRIG_INTERNAL;                                // [R08]
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_ff <= '0;
        end else if (o_frame_start || lost) begin
            cnt_ff <= '0;
        end else if (cnt_ff != LOST) begin
            cnt_ff <= cnt_ff + `SQMF_FRAME_CNT_W'(1);
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            sampled_ff <= 1'b0;
        end else if (o_frame_start || lost) begin
            sampled_ff <= 1'b0;
        end else if (o_sample) begin
            sampled_ff <= 1'b1;                                     // [R10]
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    property p_internal_start;
        @(posedge i_clock) disable iff (!i_nrst)
        (src_ff == TRIG_INTERNAL) && (cnt_ff == LAST) |-> o_frame_start && o_sample;
    endproperty
    a_internal_start: assert property (p_internal_start) // [R08]
        else $error("internal frame start missing");

    property p_ext_fall_sample;
        @(posedge i_clock) disable iff (!i_nrst)
        (src_ff == TRIG_EXTERNAL) && fall |-> o_sample;
    endproperty
    a_ext_fall_sample: assert property (p_ext_fall_sample) // [R10]
        else $error("no sync sample at trigger fall");

endmodule // sqmf_frame_timer

// File: logic/sqmf_top.sv
/*
 * S/Q multiframe channel, network side: multiframe counter, aux/marker/S bit
 * generation, Q bit capture with change interrupt, external frame and
 * multiframe sync, terminal mode marker output, APB register slave.
 * assumes the line transmitter takes o_tx at each o_frame_start and the
 * receiver presents one aux-position bit per frame with i_rx_fa_valid.
 */
`include "sqmf_cfg.svh"

module sqmf_top
    import sqmf_pkg::*;
#(
    parameter int unsigned FRAME_CYCLES = `SQMF_FRAME_CYCLES
) (
    input  wire logic        i_clock,
    input  wire logic        i_nrst,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire logic        i_frame_trigger,
    input  wire logic        i_mfsync_pin,
    output logic             o_mfsync_pin,
    output logic             o_mfsync_oe,
    input  wire logic        i_frame_sync_clock,
    input  wire logic        i_rx_fa_valid,
    input  wire logic        i_rx_fa_bit,
    input  wire logic        i_rx_m_bit,
    input  wire logic        i_rx_echo_bit,
    output sqmf_tx_bits_t    o_tx,
    output logic             o_frame_start,
    output logic             o_irq
);

    // ****************************************************************
    // declarations
    // ****************************************************************
    logic           frame_start;
    logic           sample;
    logic           ext_mode;
    logic           access;
    logic           done;
    logic           wr;
    logic           sync_now;
    logic           nxt_status;
    logic [4:0]     nxt_cnt;
    sqmf_slot_t     rx_slot;
    sqmf_slot_t     tx_slot;

    logic           pready_ff;
    logic           pslverr_ff;
    logic [31:0]    prdata_ff;
    logic           gen_en_ff;
    logic           term_ff;
    logic           mask_ff;
    logic           status_ff;
    logic           irq_ff;
    logic [3:0]     q_bits_ff;
    logic [3:0]     s_bits_ff;
    logic [4:0]     cnt_ff;
    logic           sync_val_ff;
    sqmf_tx_bits_t  tx_ff;
    logic           fstart_ff;
    logic           pin_ff;
    logic           oe_ff;

    function automatic sqmf_slot_t slot_of(input logic [4:0] n);
        sqmf_slot_t r;
        r = '{hit: 1'b1, idx: 2'h0};
        case (n)
            5'h01:   r.idx = 2'h0;
            5'h06:   r.idx = 2'h1;
            5'h0B:   r.idx = 2'h2;
            5'h10:   r.idx = 2'h3;
            default: r.hit = 1'b0;
        endcase
        return r;
    endfunction

    sqmf_frame_timer #(
        .FRAME_CYCLES (FRAME_CYCLES)
    ) u_timer (
        .i_clock       (i_clock),
        .i_nrst        (i_nrst),
        .i_trigger     (i_frame_trigger),
        .o_frame_start (frame_start),
        .o_sample      (sample),
        .o_ext_mode    (ext_mode)
    );

    // ****************************************************************
    // apb slave, one wait state
    // ****************************************************************
    assign access = i_psel & i_penable;
    assign done   = access & pready_ff;
    assign wr     = done & i_pwrite;

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else begin
            pready_ff  <= access & ~pready_ff;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
            if (access && !pready_ff) begin
                case (i_paddr)
                    `SQMF_OFS_INT_STATUS: prdata_ff[`SQMF_INT_QSC_BIT] <= status_ff;
                    `SQMF_OFS_INT_MASK:   prdata_ff[`SQMF_INT_QSC_BIT] <= mask_ff;
                    `SQMF_OFS_CTRL_TWO: begin
                        prdata_ff[`SQMF_CTRL_EN_BIT]   <= gen_en_ff;
                        prdata_ff[`SQMF_CTRL_TERM_BIT] <= term_ff;
                        prdata_ff[`SQMF_CTRL_EXT_BIT]  <= ext_mode;
                        prdata_ff[`SQMF_CTRL_FRM_LSB +: 5] <= cnt_ff;
                    end
                    `SQMF_OFS_Q_RECEIVE:  prdata_ff[3:0] <= q_bits_ff;
                    `SQMF_OFS_S_TRANSMIT: prdata_ff[3:0] <= s_bits_ff;
                    default:              pslverr_ff <= 1'b1;
                endcase
            end
        end
    end

    // ****************************************************************
    // software registers
    // ****************************************************************
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            gen_en_ff <= `SQMF_CTRL_EN_RESET;
            term_ff   <= 1'b0;
        end else if (wr && i_paddr == `SQMF_OFS_CTRL_TWO) begin
            gen_en_ff <= i_pwdata[`SQMF_CTRL_EN_BIT];                 // [R06]
            term_ff   <= i_pwdata[`SQMF_CTRL_TERM_BIT];
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            mask_ff <= `SQMF_MASK_RESET;
        end else if (wr && i_paddr == `SQMF_OFS_INT_MASK) begin
            mask_ff <= i_pwdata[`SQMF_INT_QSC_BIT];
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            s_bits_ff <= 4'h0;
        end else if (wr && i_paddr == `SQMF_OFS_S_TRANSMIT) begin
            s_bits_ff <= i_pwdata[3:0];
        end
    end

    // ****************************************************************
    // multiframe counter and sync
    // ****************************************************************
    assign sync_now = sample ? i_mfsync_pin : sync_val_ff;            // [R10]

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            sync_val_ff <= 1'b0;
        end else if (sample) begin
            sync_val_ff <= i_mfsync_pin;                              // [R10]
        end
    end

    always_comb begin
        if (!gen_en_ff || term_ff) begin
            nxt_cnt = `SQMF_MF_FIRST;                                 // [R06]
        end else if (sync_now) begin
            nxt_cnt = `SQMF_MF_FIRST;                                 // [R09] [R11]
        end else if (cnt_ff == `SQMF_MF_LAST) begin
            nxt_cnt = `SQMF_MF_FIRST;                                 // [R12]
        end else begin
            nxt_cnt = cnt_ff + 5'h01;                                 // [R12] [R13]
        end
    end

    assign tx_slot = slot_of(nxt_cnt);

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_ff    <= `SQMF_MF_FIRST;
            tx_ff     <= '0;
            fstart_ff <= 1'b0;
        end else begin
            fstart_ff <= frame_start;
            if (frame_start) begin
                cnt_ff   <= nxt_cnt;
                tx_ff.fa <= gen_en_ff & ~term_ff & tx_slot.hit;                        // [R01]
                tx_ff.m  <= gen_en_ff & ~term_ff & (nxt_cnt == `SQMF_MF_FIRST);        // [R01] [R11]
                tx_ff.s  <= gen_en_ff & ~term_ff & tx_slot.hit & s_bits_ff[tx_slot.idx]; // [R04] [R05]
            end
        end
    end

    // ****************************************************************
    // q capture and interrupt
    // ****************************************************************
    assign rx_slot = slot_of(cnt_ff);

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            q_bits_ff <= 4'h0;
        end else if (i_rx_fa_valid && rx_slot.hit && gen_en_ff && !term_ff) begin
            q_bits_ff[rx_slot.idx] <= i_rx_fa_bit;                    // [R02] [R05]
        end
    end

    always_comb begin
        nxt_status = status_ff;
        if (wr && i_paddr == `SQMF_OFS_INT_STATUS && i_pwdata[`SQMF_INT_QSC_BIT]) begin
            nxt_status = 1'b0;
        end
        if (i_rx_fa_valid && rx_slot.hit && gen_en_ff && !term_ff
            && (q_bits_ff[rx_slot.idx] != i_rx_fa_bit)) begin
            nxt_status = 1'b1;                                        // [R03]
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            status_ff <= 1'b0;
            irq_ff    <= 1'b0;
        end else begin
            status_ff <= nxt_status;
            irq_ff    <= nxt_status & mask_ff;
        end
    end

    // ****************************************************************
    // terminal mode marker output
    // ****************************************************************
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            pin_ff <= 1'b0;
            oe_ff  <= 1'b0;
        end else begin
            oe_ff  <= term_ff;
            pin_ff <= term_ff & (i_frame_sync_clock ? i_rx_m_bit : i_rx_echo_bit); // [R14]
        end
    end

    assign o_prdata      = prdata_ff;
    assign o_pready      = pready_ff;
    assign o_pslverr     = pslverr_ff;
    assign o_tx          = tx_ff;
    assign o_frame_start = fstart_ff;
    assign o_irq         = irq_ff;
    assign o_mfsync_pin  = pin_ff;
    assign o_mfsync_oe   = oe_ff;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);

    property p_fa_pattern;
        fstart_ff |-> o_tx.fa == ($past(gen_en_ff) && !$past(term_ff) && rx_slot.hit);
    endproperty
    a_fa_pattern: assert property (p_fa_pattern) // [R01]
        else $error("aux framing bit wrong");

    property p_marker;
        o_tx.m |-> cnt_ff == `SQMF_MF_FIRST;
    endproperty
    a_marker: assert property (p_marker) // [R01]
        else $error("marker outside frame 1");

    property p_q_capture;
        i_rx_fa_valid && rx_slot.hit && gen_en_ff && !term_ff
            |=> q_bits_ff[$past(rx_slot.idx)] == $past(i_rx_fa_bit);
    endproperty
    a_q_capture: assert property (p_q_capture) // [R02]
        else $error("q bit not captured");

    property p_change_irq;
        i_rx_fa_valid && rx_slot.hit && gen_en_ff && !term_ff
            && (q_bits_ff[rx_slot.idx] != i_rx_fa_bit) |=> status_ff ##1 status_ff || !mask_ff || irq_ff;
    endproperty
    a_change_irq: assert property (p_change_irq) // [R03]
        else $error("change status not set");

    property p_s_bit;
        fstart_ff && !rx_slot.hit |-> !o_tx.s;
    endproperty
    a_s_bit: assert property (p_s_bit) // [R05]
        else $error("s bit outside slot");

    property p_disabled;
        frame_start && !gen_en_ff |=> cnt_ff == `SQMF_MF_FIRST && o_tx == '0;
    endproperty
    a_disabled: assert property (p_disabled) // [R06]
        else $error("multiframe sent while disabled");

    property p_sync_reset;
        frame_start && gen_en_ff && !term_ff && sync_now |=> cnt_ff == `SQMF_MF_FIRST && o_tx.m;
    endproperty
    a_sync_reset: assert property (p_sync_reset) // [R11]
        else $error("sync did not reset counter");

    property p_advance;
        frame_start && gen_en_ff && !term_ff && !sync_now && cnt_ff != `SQMF_MF_LAST
            |=> cnt_ff == $past(cnt_ff) + 5'h01 && !o_tx.m;
    endproperty
    a_advance: assert property (p_advance) // [R12] [R13]
        else $error("counter did not advance");

    property p_wrap;
        frame_start && gen_en_ff && !sync_now && cnt_ff == `SQMF_MF_LAST
            |=> cnt_ff == `SQMF_MF_FIRST;
    endproperty
    a_wrap: assert property (p_wrap) // [R12]
        else $error("counter did not wrap");

    property p_term_out;
        term_ff ##1 term_ff |-> o_mfsync_oe
            && o_mfsync_pin == ($past(i_frame_sync_clock) ? $past(i_rx_m_bit) : $past(i_rx_echo_bit));
    endproperty
    a_term_out: assert property (p_term_out) // [R14]
        else $error("terminal marker output wrong");

    c_wrap:   cover property (frame_start && cnt_ff == `SQMF_MF_LAST && !sync_now);
    c_sync:   cover property (frame_start && sync_now && cnt_ff != `SQMF_MF_FIRST);
    c_change: cover property (nxt_status && !status_ff);
    c_ext:    cover property (ext_mode && frame_start);

endmodule // sqmf_top

// File: testbench/sqmf_line_partner.sv
/* remote line end: returns one upstream aux bit per frame.
   assumes o_tx and o_frame_start of sqmf_top. */
module sqmf_line_partner
    import sqmf_pkg::*;
(
    input  wire logic          i_clock,
    input  wire logic          i_nrst,
    input  wire sqmf_tx_bits_t i_tx,
    input  wire logic          i_frame_start,
    input  wire logic [3:0]    i_q_bits,
    output logic               o_valid,
    output logic               o_fa_bit
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] idx_ff;
    logic [4:0] nxt_idx;
    assign nxt_idx = i_tx.m ? 5'h01 : idx_ff + 5'h01;
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            idx_ff   <= 5'h00;
            o_valid  <= 1'h0;
            o_fa_bit <= 1'h0;
        end else begin
            o_valid  <= i_frame_start;
            o_fa_bit <= ~o_fa_bit;
            if (i_frame_start) begin
                idx_ff <= nxt_idx;
                case (nxt_idx)
                    5'h01: o_fa_bit <= i_q_bits[0];
                    5'h06: o_fa_bit <= i_q_bits[1];
                    5'h0B: o_fa_bit <= i_q_bits[2];
                    5'h10: o_fa_bit <= i_q_bits[3];
                    default: o_fa_bit <= 1'h0;
                endcase
            end
        end
    end
endmodule // sqmf_line_partner

// File: testbench/s_bus_multiframe_sq_channel_test.sv
/* bench of sqmf_top: apb tasks, frame walks, sync, terminal, trigger.
   assumes sqmf_line_partner on the line side. */
module s_bus_multiframe_sq_channel_test
    import sqmf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int FC = 40;
    logic          clock = 1'h0, nrst = 1'h0, psel = 1'h0, penable = 1'h0;
    logic          pwrite = 1'h0, trig = 1'h0, sync_in = 1'h0, frame_sync_clock = 1'h0;
    logic          rx_m = 1'h0, rx_echo = 1'h0, ext_on = 1'h0;
    logic [7:0]    paddr = 8'h00;
    logic [31:0]   pwdata = 32'h0, prdata, rdat;
    logic [3:0]    q_bits = 4'hB, s_reg;
    logic          pready, pslverr, mf_out, mf_oe, fs, irq, fa_valid, fa_bit, err;
    sqmf_tx_bits_t tx;
    int            bad_count = 0, cmp_count = 0, tcnt = 0, k;

    always #2.5 clock = ~clock;
    always @(posedge clock) begin
        tcnt <= (tcnt == 29) ? 0 : tcnt + 1;
        trig <= ext_on && (tcnt < 15);
    end

    sqmf_top #(.FRAME_CYCLES(FC)) dut_u (.i_clock(clock), .i_nrst(nrst),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_frame_trigger(trig), .i_mfsync_pin(sync_in),
        .o_mfsync_pin(mf_out), .o_mfsync_oe(mf_oe), .i_frame_sync_clock(frame_sync_clock),
        .i_rx_fa_valid(fa_valid), .i_rx_fa_bit(fa_bit), .i_rx_m_bit(rx_m),
        .i_rx_echo_bit(rx_echo), .o_tx(tx), .o_frame_start(fs), .o_irq(irq));
    sqmf_line_partner line_u (.i_clock(clock), .i_nrst(nrst), .i_tx(tx),
        .i_frame_start(fs), .i_q_bits(q_bits), .o_valid(fa_valid),
        .o_fa_bit(fa_bit));

    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic give_verdict;
        $display("compares %0d errors %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'h1;
        do begin
            @(posedge clock);
        end while (pready !== 1'h1);
        rdat = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic nf;
        do begin
            @(negedge clock);
        end while (fs !== 1'h1);
    endtask
    task automatic gap(input int exp);
        int w = 0;
        nf;
        do begin
            @(negedge clock);
            w++;
        end while (fs !== 1'h1 && w < 200);
        chk(w, exp);
    endtask
    function automatic logic [2:0] exp_tx(input int i, input logic [3:0] s);
        logic slot;
        slot = (i % 5 == 1);
        return {slot, i == 1, slot & s[(i - 1) / 5]};
    endfunction
    task automatic walk(input int frames);
        int idx = 0;
        repeat (frames) begin
            nf;
            if (idx == 0) idx = tx.m ? 1 : 0;
            else begin
                idx = idx % 20 + 1;
                chk(tx, exp_tx(idx, s_reg));
            end
        end
    endtask

    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        repeat (40000) @(posedge clock);
        bad_count++;
        give_verdict;
    end
    initial begin
        repeat (10) @(posedge clock);
        nrst <= 1'h1;
        apb(1'h0, 8'h08, 32'h0);
        chk(rdat, 32'h101);
        apb(1'h0, 8'h40, 32'h0);
        chk(err, 1'h1);
        s_reg = 4'hA;
        apb(1'h1, 8'h10, 32'hA);
        walk(45);
        apb(1'h0, 8'h0C, 32'h0);
        chk(rdat, 32'hB);
        apb(1'h0, 8'h00, 32'h0);
        chk(rdat, 32'h1);
        chk(irq, 1'h0);
        apb(1'h1, 8'h04, 32'h1);
        repeat (2) @(negedge clock);
        chk(irq, 1'h1);
        apb(1'h1, 8'h00, 32'h1);
        repeat (2) @(negedge clock);
        chk(irq, 1'h0);
        @(posedge clock) q_bits <= 4'h4;
        walk(21);
        apb(1'h0, 8'h0C, 32'h0);
        chk(rdat, 32'h4);
        chk(irq, 1'h1);
        @(posedge clock) sync_in <= 1'h1;
        repeat (3) nf;
        repeat (3) begin
            nf;
            chk(tx.m, 1'h1);
        end
        @(posedge clock) sync_in <= 1'h0;
        k = 0;
        while (tx.m === 1'h1 && k < 5) begin
            nf;
            k++;
        end
        k = 1;
        nf;
        while (tx.m !== 1'h1 && k < 40) begin
            k++;
            nf;
        end
        chk(k, 19);
        @(posedge clock) sync_in <= 1'h1;
        repeat (4) nf;
        @(posedge clock) sync_in <= 1'h0;
        nf;
        k = (tx.m === 1'h0);
        @(posedge clock) sync_in <= 1'h1;
        repeat (5) begin
            nf;
            k += (tx.m === 1'h0);
        end
        chk(k, 1);
        apb(1'h1, 8'h08, 32'h0);
        nf;
        k = 0;
        repeat (3 * FC) begin
            @(negedge clock);
            k += (tx !== 3'h0);
        end
        chk(k, 0);
        apb(1'h1, 8'h08, 32'h2);
        @(posedge clock);
        frame_sync_clock <= 1'h1;
        rx_m <= 1'h1;
        repeat (3) @(negedge clock);
        chk({mf_oe, mf_out}, 2'h3);
        @(posedge clock) frame_sync_clock <= 1'h0;
        repeat (3) @(negedge clock);
        chk({mf_oe, mf_out}, 2'h2);
        @(posedge clock) rx_echo <= 1'h1;
        repeat (3) @(negedge clock);
        chk({mf_oe, mf_out}, 2'h3);
        apb(1'h1, 8'h08, 32'h1);
        @(posedge clock) ext_on <= 1'h1;
        repeat (3) nf;
        gap(30);
        apb(1'h0, 8'h08, 32'h0);
        chk(rdat & 32'h4, 32'h4);
        @(posedge clock) ext_on <= 1'h0;
        repeat (4) nf;
        gap(FC);
        give_verdict;
    end
endmodule // s_bus_multiframe_sq_channel_test
